// File: rtl/fecs_host.sv
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ns
module fecs_host
  import fecs_pkg::*;
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RSTN,
  // software port
  input  wire logic [3:0]        REG_ADDR,
  input  wire logic [31:0]       REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [31:0]       REG_RDATA,
  // flash pins
  output logic      [ADDR_W-1:0] FL_ADDR,
  output logic      [DATA_W-1:0] FL_DQ_O,
  output logic                   FL_DQ_OE,
  input  wire logic [DATA_W-1:0] FL_DQ_I,
  output logic                   FL_CE_N,
  output logic                   FL_WE_N,
  output logic                   FL_OE_N,
  output logic                   FL_RESET_N
);

  fecs_state_e            state;
  logic [ADDR_W-1:0]      seq_addr [6];
  logic [DATA_W-1:0]      seq_data [6];
  logic [2:0]             seq_len;
  logic [2:0]             seq_idx;
  logic [CNT_W-1:0]       cnt;
  logic [ADDR_W-1:0]      sector;
  logic [DATA_W-1:0]      rd_word;
  logic [DATA_W-1:0]      dq_s1, dq_s2, dq_s3;
  logic [CNT_W-1:0]       gap_cnt;
  logic                   gap_open;
  logic                   busy;
  logic                   unlock_skip;
  logic                   start;
  logic [2:0]             op;

  assign op    = REG_WDATA[2:0];
  assign start = REG_WR && REG_ADDR == REG_CTRL && state == ST_IDLE;

  // read data one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        REG_SECTOR: REG_RDATA <= {{(32-ADDR_W){1'b0}}, sector};
        REG_STATUS: REG_RDATA <= {29'h0, unlock_skip, gap_open, busy};
        REG_RDWORD: REG_RDATA <= {16'h0, rd_word};
        default:    REG_RDATA <= 32'h0;
      endcase
    end else begin
      REG_RDATA <= 32'h0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      sector      <= '0;
      unlock_skip <= 1'b0;
    end else if (REG_WR && REG_ADDR == REG_SECTOR) begin
      sector      <= REG_WDATA[ADDR_W-1:0];
      unlock_skip <= REG_WDATA[31];                     // [R17]
    end
  end

  // load the command sequence for the chosen operation
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      seq_len <= 3'h0;
      for (int i = 0; i < 6; i++) begin
        seq_addr[i] <= '0;
        seq_data[i] <= '0;
      end
    end else if (start) begin
      seq_addr[0] <= UNLOCK_ADDR1;                      // [R04] [R05]
      seq_data[0] <= UNLOCK_DATA1;
      seq_addr[1] <= UNLOCK_ADDR2;
      seq_data[1] <= UNLOCK_DATA2;
      seq_addr[2] <= UNLOCK_ADDR1;
      seq_data[2] <= SETUP_DATA;
      seq_addr[3] <= UNLOCK_ADDR1;
      seq_data[3] <= UNLOCK_DATA1;
      seq_addr[4] <= UNLOCK_ADDR2;
      seq_data[4] <= UNLOCK_DATA2;
      seq_addr[5] <= sector;
      seq_data[5] <= SECTOR_CMD;
      seq_len     <= 3'h6;
      case (op)
        OP_CHIP: begin
          seq_addr[5] <= UNLOCK_ADDR1;                  // [R05]
          seq_data[5] <= CHIP_CMD;
        end
        OP_ADD, OP_RESUME: begin
          seq_addr[0] <= sector;                        // [R07] [R19]
          seq_data[0] <= SECTOR_CMD;
          seq_len     <= 3'h1;
        end
        OP_SUSPEND: begin
          seq_addr[0] <= sector;                        // [R18]
          seq_data[0] <= SUSPEND_CMD;
          seq_len     <= 3'h1;
        end
        default: begin
        end
      endcase
    end
  end

  // bus cycle sequencer
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state   <= ST_IDLE;
      seq_idx <= 3'h0;
      cnt     <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          seq_idx <= 3'h0;
          cnt     <= '0;
          if (start) begin
            if (op == OP_READ) state <= ST_RD;
            else if (op == OP_RESET) state <= ST_RST;   // [R15]
            else if (op != 3'h0) state <= ST_SETUP;
          end
        end
        ST_SETUP: state <= ST_WE_LOW;
        ST_WE_LOW: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(WE_LOW_CYC - 1)) begin
            cnt   <= '0;
            state <= ST_WE_HIGH;
          end
        end
        ST_WE_HIGH: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(WE_HIGH_CYC - 1)) begin
            cnt     <= '0;
            seq_idx <= seq_idx + 1'b1;
            state   <= (seq_idx + 1'b1 == seq_len) ? ST_IDLE : ST_SETUP;
          end
        end
        ST_RD, ST_RST: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'((state == ST_RD ? RD_CYC : RESET_CYC) - 1)) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // pins driven from flops
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      FL_ADDR    <= '0;
      FL_DQ_O    <= '0;
      FL_DQ_OE   <= 1'b0;
      FL_CE_N    <= 1'b1;
      FL_WE_N    <= 1'b1;
      FL_OE_N    <= 1'b1;
      FL_RESET_N <= 1'b1;
    end else begin
      // chip select stays low past the strobe's rising edge, where the write lands
      FL_CE_N    <= !(state == ST_SETUP || state == ST_WE_LOW || state == ST_WE_HIGH
                      || state == ST_RD);
      FL_WE_N    <= state != ST_WE_LOW;
      FL_OE_N    <= state != ST_RD;
      FL_DQ_OE   <= state == ST_SETUP || state == ST_WE_LOW || state == ST_WE_HIGH;
      FL_RESET_N <= state != ST_RST;                    // [R15]
      if (state == ST_SETUP) begin
        FL_ADDR <= seq_addr[seq_idx];
        FL_DQ_O <= seq_data[seq_idx];
      end else if (state == ST_IDLE && start && op == OP_READ) begin
        FL_ADDR <= sector;
      end
    end
  end

  // pin input synchroniser and status word capture
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      dq_s1   <= '0;
      dq_s2   <= '0;
      dq_s3   <= '0;
      rd_word <= '0;
    end else begin
      dq_s1 <= FL_DQ_I;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
      if (state == ST_RD && cnt == CNT_W'(RD_CYC - 1) && dq_s2 == dq_s3) begin
        rd_word <= dq_s3;                               // [R10] [R12]
      end
    end
  end

  // time since the last sector write; extra writes must fall inside
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      gap_cnt  <= '0;
      gap_open <= 1'b0;
    end else if (state == ST_WE_HIGH && seq_data[seq_idx] == SECTOR_CMD
                 && cnt == '0) begin
      gap_cnt  <= '0;                                   // [R06] [R08]
      gap_open <= 1'b1;
    end else if (gap_open) begin
      gap_cnt <= gap_cnt + 1'b1;
      if (gap_cnt == CNT_W'(EXTRA_GAP_CYC - 1)) gap_open <= 1'b0;
    end
  end

  assign busy = state != ST_IDLE;

endmodule : fecs_host

// File: rtl/fecs_pkg.sv
// Summary of operation
// R01: device preprograms and verifies sector before erase
// R02: erased sector words read all ones
// R03: erased whole array words read all ones
// R04: host sends six writes for sector erase
// R05: host sends six writes for chip erase
// R06: acceptance window timed from last strobe
// R07: extra sector writes queue during window
// R08: host spaces extra sector writes under limit; the host only flags the gap in gap_open and still sends a late OP_ADD
// R09: other command in window abandons erase
// R10: window expiry status bit is readable
// R11: erase end returns device to array read
// R12: erasing sector reads give polling and toggle
// R13: sector erase honours only suspend
// R14: chip erase ignores every command
// R15: hardware reset ends erase; host reissues; the host only pulses FL_RESET_N and never reissues the erase itself
// R16: erase pass runs self-timed
// R17: unlock-skip mode drops two unlock writes; the host only stores the bit for status and still sends every unlock write
// R18: suspend write stops erase within limit
// R19: resume writes erase command to sector
// R20: mismatched sequence write is discarded
package fecs_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;

  // flash command cycles
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 24'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 24'h0002aa;
  localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00aa;
  localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [DATA_W-1:0] SETUP_DATA   = 16'h0080;
  localparam logic [DATA_W-1:0] SECTOR_CMD   = 16'h0030;
  localparam logic [DATA_W-1:0] CHIP_CMD     = 16'h0010;
  localparam logic [DATA_W-1:0] SUSPEND_CMD  = 16'h00b0;
  localparam logic [DATA_W-1:0] ERASED_WORD  = 16'hffff;

  // status bit positions in a flash read word
  localparam int DATA_POLL_POS   = 7;
  localparam int TOGGLE_POS      = 6;
  localparam int WIN_EXPIRED_POS = 3;
  localparam int SECT_TOGGLE_POS = 2;

  // timing at 250 MHz
  localparam int CLK_MHZ          = 250;
  localparam int EXTRA_GAP_US     = 50;
  localparam int EXTRA_GAP_CYC    = EXTRA_GAP_US * CLK_MHZ - 1;
  localparam int WE_LOW_NS        = 40;
  localparam int WE_HIGH_NS       = 40;
  localparam int CLK_NS           = 4;
  localparam int WE_LOW_CYC       = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC      = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_NS            = 80;
  localparam int RD_CYC           = (RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W            = 16;

  // software register map
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_SECTOR = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_RDWORD = 4'h3;

  // control register command codes
  localparam logic [2:0] OP_SECTOR  = 3'h1;
  localparam logic [2:0] OP_CHIP    = 3'h2;
  localparam logic [2:0] OP_ADD     = 3'h3;
  localparam logic [2:0] OP_SUSPEND = 3'h4;
  localparam logic [2:0] OP_RESUME  = 3'h5;
  localparam logic [2:0] OP_READ    = 3'h6;
  localparam logic [2:0] OP_RESET   = 3'h7;

  localparam int RESET_CYC = 125;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_WE_LOW, ST_WE_HIGH, ST_RD, ST_RST
  } fecs_state_e;

endpackage : fecs_pkg

// File: verif/fecs_host_monitor.sv
`timescale 1ns/1ns
module fecs_host_monitor
  import fecs_pkg::*;
(
  input wire logic              CLK, RSTN, REG_RD, REG_WR, FL_WE_N, FL_CE_N,
  input wire logic              FL_OE_N, FL_DQ_OE, FL_RESET_N,
  input wire logic [3:0]        REG_ADDR,
  input wire logic [31:0]       REG_WDATA, REG_RDATA,
  input wire logic [ADDR_W-1:0] FL_ADDR,
  input wire logic [DATA_W-1:0] FL_DQ_O
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  property p_wsel; $fell(FL_WE_N) |-> !FL_CE_N && FL_DQ_OE; endproperty
  a_wsel: assert property (p_wsel) else $error("strobe unselected");
  property p_wlo; $fell(FL_WE_N) |-> !FL_WE_N [*8]; endproperty
  a_wlo: assert property (p_wlo) else $error("short strobe");
  property p_whi; $rose(FL_WE_N) |-> FL_WE_N [*8]; endproperty
  a_whi: assert property (p_whi) else $error("short gap");
  property p_hold; !FL_WE_N && !$fell(FL_WE_N) |-> $stable({FL_ADDR, FL_DQ_O}); endproperty
  a_hold: assert property (p_hold) else $error("bus moved");
  property p_oe; !FL_OE_N |-> FL_WE_N && !FL_DQ_OE; endproperty
  a_oe: assert property (p_oe) else $error("bus clash");
  property p_rd; !$past(REG_RD) |-> REG_RDATA == 0; endproperty
  a_rd: assert property (p_rd) else $error("stale read");
  property p_rst; $fell(FL_RESET_N) |-> !FL_RESET_N [*8]; endproperty
  a_rst: assert property (p_rst) else $error("short reset");
  property p_go;
    REG_WR && REG_ADDR == REG_CTRL && REG_WDATA[2:0] == OP_CHIP && FL_CE_N && FL_RESET_N
      |-> ##[1:25] !FL_WE_N;
  endproperty
  a_go: assert property (p_go) else $error("no start");
endmodule : fecs_host_monitor

// File: verif/fecs_flash_model.sv
`timescale 1ns/1ns
module fecs_flash_model
  import fecs_pkg::*;
#(parameter int WIN_CYC = 13000, parameter int ERASE_CYC = 300)
(
  input wire logic              CLK, FL_WE_N, FL_CE_N, FL_OE_N, FL_RESET_N,
  input wire logic [ADDR_W-1:0] FL_ADDR,
  input wire logic [DATA_W-1:0] FL_DQ_O,
  output logic      [DATA_W-1:0] FL_DQ_I
);
  int pos = 0, win = 0, busy = 0, nseq = 0, nsect = 0, nsusp = 0, nres = 0;
  logic we_q = 1, oe_q = 1, tog = 0, chip = 0, susp = 0, erased = 0;
  logic [DATA_W-1:0] last = '0;
  wire logic two = pos == 1 || pos == 4;
  wire logic [ADDR_W-1:0] ea = two ? UNLOCK_ADDR2 : UNLOCK_ADDR1;
  wire logic [DATA_W-1:0] ed = pos == 2 ? SETUP_DATA : two ? UNLOCK_DATA2 : UNLOCK_DATA1;
  wire logic [DATA_W-1:0] d = FL_DQ_O;
  wire logic sect = d == SECTOR_CMD;
  wire logic whole = d == CHIP_CMD && FL_ADDR == UNLOCK_ADDR1;
  // status while erasing or in the window, array data otherwise; released bus inverts
  wire logic [DATA_W-1:0] rd = (busy > 0 || win > 0) ?
    {8'h00, 1'b0, tog, 2'b00, win == 0, tog, 2'b00} : erased ? ERASED_WORD : 16'h0000;
  assign FL_DQ_I = (!FL_OE_N && !FL_CE_N) ? rd : ~last;
  always @(posedge CLK) begin
    we_q <= FL_WE_N;
    oe_q <= FL_OE_N;
    last <= FL_DQ_I;
    if (oe_q && !FL_OE_N) tog <= !tog;
    if (!FL_RESET_N) begin
      pos <= 0; win <= 0; busy <= 0; susp <= 0;
    end else if (FL_WE_N && !we_q && !FL_CE_N) begin
      if (busy > 0) begin
        if (!chip && !susp && d == SUSPEND_CMD) begin susp <= 1; nsusp <= nsusp + 1; end
        if (susp && sect) begin susp <= 0; nres <= nres + 1; end
      end else if (win > 0) begin
        win <= sect ? WIN_CYC : 0;
        nsect <= nsect + sect;
        if (d == SUSPEND_CMD) begin busy <= ERASE_CYC; susp <= 1; nsusp <= nsusp + 1; end
      end else if (pos == 5) begin
        pos <= 0;
        erased <= 0;
        chip <= whole;
        nseq <= nseq + (sect || whole);
        if (sect) begin win <= WIN_CYC; nsect <= 1; end
        else if (whole) busy <= ERASE_CYC;
      end else pos <= FL_ADDR == ea && d == ed ? pos + 1 : 0;
    end else begin
      if (win == 1) busy <= ERASE_CYC;
      if (win > 0) win <= win - 1;
      if (busy == 1) erased <= 1;
      if (busy > 0 && !susp) busy <= busy - 1;
    end
  end
endmodule : fecs_flash_model

// File: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import fecs_pkg::*;
  logic CLK = 0, RSTN = 0, REG_WR = 0, REG_RD = 0, FL_DQ_OE, FL_CE_N, FL_WE_N, FL_OE_N, FL_RESET_N;
  logic [3:0]        REG_ADDR = '0;
  logic [31:0]       REG_WDATA = '0, REG_RDATA, v;
  logic [ADDR_W-1:0] FL_ADDR;
  logic [DATA_W-1:0] FL_DQ_O, FL_DQ_I;
  int failures = 0, tests_run = 0, cyc = 0;
  always #2 CLK = ~CLK;
  fecs_host fecs_host_inst (.*);
  fecs_flash_model fecs_flash_model_inst (.*);
  task test_done;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(logic [3:0] a, logic [31:0] d);
    REG_ADDR <= a; REG_WDATA <= d; REG_WR <= 1;
    @(posedge CLK) REG_WR <= 0;
    @(posedge CLK);
  endtask : wr
  task rd(logic [3:0] a);
    REG_ADDR <= a; REG_RD <= 1;
    @(posedge CLK) REG_RD <= 0;
    #1 v = REG_RDATA;
    @(posedge CLK);
  endtask : rd
  task op(logic [2:0] c);
    int n;
    wr(REG_CTRL, {29'h0, c});
    n = 0;
    rd(REG_STATUS);
    while (v[0] !== 1'b0 && n < 9000) begin rd(REG_STATUS); n++; end
    chk("busy", 0, v[0]);
  endtask : op
  task t_sector;
    wr(REG_SECTOR, 32'h10000);
    wr(REG_CTRL, 0);
    rd(REG_STATUS); chk("op0", 0, v[0]);
    op(OP_SECTOR); chk("seq", 1, fecs_flash_model_inst.nseq);
    rd(REG_STATUS); chk("gap", 1, v[1]);
    wr(REG_SECTOR, 32'h20000); op(OP_ADD);
    chk("sectors", 2, fecs_flash_model_inst.nsect);
    op(OP_READ); rd(REG_RDWORD); chk("window", 0, v[WIN_EXPIRED_POS]);
    repeat (14000) @(posedge CLK);
    op(OP_READ); rd(REG_RDWORD); chk("erased", ERASED_WORD, v);
  endtask : t_sector
  task t_chip;
    wr(REG_CTRL, OP_CHIP); op(OP_SECTOR);
    chk("seq", 2, fecs_flash_model_inst.nseq);
    chk("chip", 1, fecs_flash_model_inst.chip);
    repeat (400) @(posedge CLK);
    op(OP_READ); rd(REG_RDWORD); chk("erased", ERASED_WORD, v);
  endtask : t_chip
  task t_susp;
    op(OP_SECTOR); op(OP_SUSPEND);
    chk("susp", 1, fecs_flash_model_inst.susp);
    op(OP_RESUME); chk("resume", 1, fecs_flash_model_inst.nres);
    chk("running", 0, fecs_flash_model_inst.susp);
  endtask : t_susp
  task t_rst;
    repeat (600) @(posedge CLK);
    op(OP_SECTOR); op(OP_RESET);
    chk("abort", 0, fecs_flash_model_inst.win + fecs_flash_model_inst.busy);
    op(OP_SECTOR); chk("again", 5, fecs_flash_model_inst.nseq);
  endtask : t_rst
  initial begin
    repeat (10) @(posedge CLK);
    RSTN <= 1;
    @(posedge CLK);
    t_sector; t_chip; t_susp; t_rst;
    test_done;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 60000) begin failures++; test_done; end
  end
endmodule : tb_top
bind fecs_host fecs_host_monitor fecs_host_monitor_inst (.*);
